/* dv/halfbridge_gate_state_ctl_tb.sv */
// self-checking bench for hb_gate_host: register rows, then pin-level sequences
// assumes hb_driver_model on the pins and a pull-up on the shared fault line
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module halfbridge_gate_state_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    bit          w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic [31:0] m;
    logic        e;
  } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pwm_level, pwm_drive_n, drv_enable, fault_out, fault_oe_n;
  logic        fault_line, dev_pull, tb_pull, over_temp, ug_src, ug_snk, lg_src, lg_snk;
  int          bad_count, n_tests, cyc;
  row_t        rows [13] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 32'hffffffff, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h14, 32'hffffffff, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'ha, 32'hffffffff, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 32'h0, 32'h7, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 32'hffffffff, 1'b1},
    '{1'b1, 8'h04, 32'h6, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h6, 32'hffffffff, 1'b0},
    '{1'b1, 8'h08, 32'h2, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h2, 32'hffffffff, 1'b0},
    '{1'b1, 8'h44, 32'h1ff, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h04, 32'h0, 32'h6, 32'hffffffff, 1'b0},
    '{1'b1, 8'h0c, 32'h7, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 32'h0, 32'h7, 1'b0}
  };

  // open drain: any party pulling wins over the pull-up
  assign fault_line = ((!fault_oe_n && !fault_out) || dev_pull || tb_pull) ? 1'b0 : 1'b1;

  hb_gate_host DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_level(pwm_level), .pwm_drive_n(pwm_drive_n), .drv_enable(drv_enable),
    .fault_in(fault_line), .fault_out(fault_out), .fault_oe_n(fault_oe_n)
  );
  hb_driver_model drv (
    .pwm_level(pwm_level), .pwm_drive_n(pwm_drive_n), .enable(drv_enable),
    .supply_lockout(1'b0), .boot_lockout(1'b0), .over_temp(over_temp),
    .phase_node_sense(1'b1), .shared_fault_line(fault_line),
    .upper_gate_source(ug_src), .upper_gate_sink(ug_snk), .lower_gate_source(lg_src),
    .lower_gate_sink(lg_snk), .boot_switch(), .fault_pull(dev_pull)
  );

  always #25 pclk = ~pclk;

  // hang guard, well above the few hundred cycles the sequences need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // boot refresh then first run period; sampled mid-cycle so outputs are settled
  task automatic refresh_chk();
    int   lo, hi, pul, k;
    logic prv;
    lo = 0;
    hi = 0;
    pul = 0;
    k = 0;
    prv = 1'b1;
    @(negedge pclk);
    while (pwm_drive_n !== 1'b0 && k < 40) begin
      k++;
      @(negedge pclk);
    end
    for (int i = 0; i < 128; i++) begin
      if (pwm_drive_n === 1'b0 && prv === 1'b1) pul++;
      if (pwm_drive_n === 1'b0 && pwm_level === 1'b1) hi++;
      if (pwm_drive_n === 1'b0 && pwm_level === 1'b0) lo++;
      prv = pwm_drive_n;
      @(negedge pclk);
    end
    `CHK("refresh pulses", 32, pul)
    `CHK("refresh low cycles", 64, lo)
    `CHK("high during refresh", 0, hi)
    `CHK("upper gate on", 1'b1, ug_src)
    k = 0;
    while (pwm_drive_n === 1'b0 && pwm_level === 1'b1 && k < 20) begin
      k++;
      @(negedge pclk);
    end
    `CHK("high cycles", 2, k)
    k = 0;
    while (pwm_drive_n === 1'b0 && pwm_level === 1'b0 && k < 20) begin
      k++;
      @(negedge pclk);
    end
    `CHK("low cycles", 4, k)
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tb_pull = 1'b0;
    over_temp = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("pwm after reset", 1'b1, pwm_drive_n)
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("register row", rows[i].exp & rows[i].m, rd & rows[i].m)
      `CHK("slverr", rows[i].e, err)
    end
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h5);
    refresh_chk();
    $display("test refresh done");
    // outside pull, then over-temperature; each recovers with a full refresh
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      if (k == 0) tb_pull <= 1'b1;
      else over_temp <= 1'b1;
      repeat (5) @(negedge pclk);
      `CHK("abort float", 1'b1, pwm_drive_n)
      `CHK("upper sink", 1'b1, ug_snk)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK("status after abort", 32'h20, rd & 32'h37)
      tb_pull <= 1'b0;
      over_temp <= 1'b0;
      apb(1'b1, 8'h00, 32'h4);
      apb(1'b1, 8'h0c, 32'h20);
      apb(1'b0, 8'h0c, 32'h0);
      `CHK("seen cleared", 32'h0, rd & 32'h20)
      apb(1'b1, 8'h00, 32'h5);
      refresh_chk();
    end
    $display("test abort done");
    apb(1'b1, 8'h00, 32'h7);
    @(negedge pclk);
    `CHK("own pull", 1'b0, fault_line)
    repeat (5) @(negedge pclk);
    `CHK("own fault float", 1'b1, pwm_drive_n)
    apb(1'b1, 8'h00, 32'h0);
    @(negedge pclk);
    `CHK("disabled", 2'b01, {drv_enable, fault_oe_n})
    `CHK("passive sinks", 2'b00, {ug_snk, lg_snk})
    $display("test own fault done");
    apb(1'b1, 8'h00, 32'h5);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    `CHK("reset float", 2'b10, {pwm_drive_n, drv_enable})
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl after reset", 32'h0, rd)
    $display("test mid reset done");
    conclude();
  end
endmodule

/* dv/hb_driver_model.sv */
// behavioural half-bridge gate driver seen from the controller's pwm and fault pins
// assumes the bench resolves the open-drain fault line and sets the supply flags
module hb_driver_model #(
  parameter int HS_DEAD_NS = 20,
  parameter int LS_DEAD_NS = 15
) (
  input  wire logic pwm_level,
  input  wire logic pwm_drive_n,
  input  wire logic enable,
  input  wire logic supply_lockout,
  input  wire logic boot_lockout,
  input  wire logic over_temp,
  input  wire logic phase_node_sense,
  input  wire logic shared_fault_line,
  output logic      upper_gate_source,
  output logic      upper_gate_sink,
  output logic      lower_gate_source,
  output logic      lower_gate_sink,
  output logic      boot_switch,
  output logic      fault_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cmd_hi, cmd_lo, passive, active, hs_on, ls_on, hs_dly, ls_dly;
  // the pin arrives already split into low, mid and high
  assign cmd_hi = !pwm_drive_n && pwm_level;
  assign cmd_lo = !pwm_drive_n && !pwm_level;
  // passive off outranks every active-off cause
  assign passive = !enable || supply_lockout;
  assign active = pwm_drive_n || !shared_fault_line || over_temp;
  assign hs_on = !passive && !boot_lockout && !active && cmd_hi;
  assign ls_on = !passive && !active && cmd_lo;
  // only rising edges are delayed; delays are plain ns, values above 50 carry no promise
  assign #(HS_DEAD_NS) hs_dly = hs_on;
  assign #(LS_DEAD_NS) ls_dly = ls_on;
  assign upper_gate_source = hs_on && hs_dly;
  assign lower_gate_source = ls_on && ls_dly;
  assign upper_gate_sink = !passive && !boot_lockout && !hs_on;
  assign lower_gate_sink = !passive && !ls_on;
  // no refresh while the phase node swings in dead time
  assign boot_switch = !passive && cmd_lo && phase_node_sense;
  // the temperature flag is not latched, so release is automatic
  assign fault_pull = passive || over_temp;
endmodule

/* hw/hb_gate_host.sv */
// controller for a tri-level PWM half-bridge gate driver, with an APB register slave
// assumes the driver pins are joined by the bench: pwm floats for mid level,
// the shared fault line is open drain with an outside pull-up
//
// The APB register port and the register addresses were decided locally.
module hb_gate_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_level,
  output logic             pwm_drive_n,
  output logic             drv_enable,
  input  wire logic        fault_in,
  output logic             fault_out,
  output logic             fault_oe_n
);

  typedef struct packed {
    hb_host_pkg::host_st_t                st;
    logic [1:0]                           flt_sync;
    logic [hb_host_pkg::CTRL_W-1:0]       ctrl;
    logic [hb_host_pkg::TIMER_W-1:0]      period;
    logic [hb_host_pkg::TIMER_W-1:0]      on_time;
    logic                                 fault_seen;
    logic [hb_host_pkg::PULSE_W-1:0]      pulses;
    logic                                 pwm_hi;
    logic                                 pwm_drv;
    logic [31:0]                          rdata;
  } host_state_t;

  localparam logic [hb_host_pkg::TIMER_W-1:0] MIN_CYC =
    hb_host_pkg::TIMER_W'(hb_host_pkg::MIN_PULSE_CYC);
  localparam logic [hb_host_pkg::TIMER_W-1:0] LOW_LOAD =
    hb_host_pkg::TIMER_W'(hb_host_pkg::REFRESH_LOW_CYC - 1);
  localparam logic [hb_host_pkg::TIMER_W-1:0] MID_LOAD =
    hb_host_pkg::TIMER_W'(hb_host_pkg::REFRESH_MID_CYC - 1);
  localparam logic [hb_host_pkg::PULSE_W-1:0] LAST_PULSE =
    hb_host_pkg::PULSE_W'(hb_host_pkg::REFRESH_PULSES - 1);

  host_state_t                     q_ff;
  host_state_t                     nxt_q;
  logic                            tmr_load;
  logic [hb_host_pkg::TIMER_W-1:0] tmr_val;
  logic                            tmr_expired;
  logic                            fault_low;
  logic                            abort;
  logic                            mapped;
  logic                            wr_en;
  logic [hb_host_pkg::TIMER_W-1:0] high_len;
  logic [hb_host_pkg::TIMER_W-1:0] low_len;
  logic [hb_host_pkg::TIMER_W-1:0] low_raw;

  phase_timer #(.W(hb_host_pkg::TIMER_W)) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // only the second synchroniser stage is looked at
  assign fault_low = !q_ff.flt_sync[1];
  assign abort     = fault_low || !q_ff.ctrl[hb_host_pkg::CTRL_RUN_BIT]
                     || !q_ff.ctrl[hb_host_pkg::CTRL_DRV_EN_BIT];
  assign mapped    = (paddr == hb_host_pkg::CTRL_OFF) || (paddr == hb_host_pkg::PERIOD_OFF)
                     || (paddr == hb_host_pkg::ON_OFF) || (paddr == hb_host_pkg::STATUS_OFF);
  assign wr_en     = psel && penable && pwrite && mapped;

  // phases shorter than the minimum pulse are stretched, so duty is not exact near 0 or 100 %
  assign low_raw   = (q_ff.period > q_ff.on_time) ? (q_ff.period - q_ff.on_time) : '0;
  assign high_len  = (q_ff.on_time < MIN_CYC) ? MIN_CYC : q_ff.on_time;
  assign low_len   = (low_raw < MIN_CYC) ? MIN_CYC : low_raw;

  always_comb begin
    nxt_q    = q_ff;
    tmr_load = 1'b0;
    tmr_val  = '0;
    nxt_q.flt_sync = {q_ff.flt_sync[0], fault_in};

    // register writes; a fault seen in the same cycle as its clear is kept
    if (wr_en) begin
      case (paddr)
        hb_host_pkg::CTRL_OFF:   nxt_q.ctrl = pwdata[hb_host_pkg::CTRL_W-1:0];
        hb_host_pkg::PERIOD_OFF: nxt_q.period = pwdata[hb_host_pkg::TIMER_W-1:0];
        hb_host_pkg::ON_OFF:     nxt_q.on_time = pwdata[hb_host_pkg::TIMER_W-1:0];
        hb_host_pkg::STATUS_OFF: begin
          if (pwdata[hb_host_pkg::STAT_FLT_SEEN_BIT]) begin
            nxt_q.fault_seen = 1'b0;
          end
        end
        default: nxt_q.ctrl = q_ff.ctrl;
      endcase
    end
    if (fault_low) begin
      nxt_q.fault_seen = 1'b1;
    end

    // read data latched in the setup cycle so it comes from a register
    if (psel && !penable) begin
      nxt_q.rdata = '0;
      case (paddr)
        hb_host_pkg::CTRL_OFF:   nxt_q.rdata[hb_host_pkg::CTRL_W-1:0] = q_ff.ctrl;
        hb_host_pkg::PERIOD_OFF: nxt_q.rdata[hb_host_pkg::TIMER_W-1:0] = q_ff.period;
        hb_host_pkg::ON_OFF:     nxt_q.rdata[hb_host_pkg::TIMER_W-1:0] = q_ff.on_time;
        hb_host_pkg::STATUS_OFF: begin
          nxt_q.rdata[hb_host_pkg::STAT_STATE_LSB +: 3]          = q_ff.st;
          nxt_q.rdata[hb_host_pkg::STAT_FLT_LVL_BIT]             = q_ff.flt_sync[1];
          nxt_q.rdata[hb_host_pkg::STAT_FLT_SEEN_BIT]            = q_ff.fault_seen;
          nxt_q.rdata[hb_host_pkg::STAT_PULSE_LSB +: hb_host_pkg::PULSE_W] = q_ff.pulses;
        end
        default: nxt_q.rdata = '0;
      endcase
    end

    // command sequencer; any stop floats the command to mid level
    case (q_ff.st)
      hb_host_pkg::ST_IDLE: begin
        nxt_q.pwm_drv = 1'b0;
        if (!abort) begin
          nxt_q.st      = hb_host_pkg::ST_REFRESH_LOW;
          nxt_q.pulses  = '0;
          nxt_q.pwm_drv = 1'b1;
          nxt_q.pwm_hi  = 1'b0;
          tmr_load      = 1'b1;
          tmr_val       = LOW_LOAD;
        end
      end
      hb_host_pkg::ST_REFRESH_LOW: begin
        if (abort) begin
          nxt_q.st      = hb_host_pkg::ST_IDLE;
          nxt_q.pwm_drv = 1'b0;
        end else if (tmr_expired) begin
          nxt_q.st      = hb_host_pkg::ST_REFRESH_MID;
          nxt_q.pwm_drv = 1'b0;
          tmr_load      = 1'b1;
          tmr_val       = MID_LOAD;
        end
      end
      hb_host_pkg::ST_REFRESH_MID: begin
        if (abort) begin
          nxt_q.st = hb_host_pkg::ST_IDLE;
        end else if (tmr_expired) begin
          nxt_q.pulses  = q_ff.pulses + hb_host_pkg::PULSE_W'(1);
          nxt_q.pwm_drv = 1'b1;
          tmr_load      = 1'b1;
          if (q_ff.pulses == LAST_PULSE) begin
            nxt_q.st     = hb_host_pkg::ST_RUN;
            nxt_q.pwm_hi = 1'b1;
            tmr_val      = high_len - hb_host_pkg::TIMER_W'(1);
          end else begin
            nxt_q.st     = hb_host_pkg::ST_REFRESH_LOW;
            nxt_q.pwm_hi = 1'b0;
            tmr_val      = LOW_LOAD;
          end
        end
      end
      hb_host_pkg::ST_RUN: begin
        if (abort) begin
          nxt_q.st      = hb_host_pkg::ST_IDLE;
          nxt_q.pwm_drv = 1'b0;
          nxt_q.pwm_hi  = 1'b0;
        end else if (tmr_expired) begin
          nxt_q.pwm_hi = !q_ff.pwm_hi;
          tmr_load     = 1'b1;
          tmr_val      = q_ff.pwm_hi ? (low_len - hb_host_pkg::TIMER_W'(1))
                                     : (high_len - hb_host_pkg::TIMER_W'(1));
        end
      end
      default: begin
        nxt_q.st      = hb_host_pkg::ST_IDLE;
        nxt_q.pwm_drv = 1'b0;
        nxt_q.pwm_hi  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff          <= '0;
      // the line idles high under its pull-up, so reset must not look like a fault
      q_ff.flt_sync <= '1;
      q_ff.st       <= hb_host_pkg::ST_IDLE;
      q_ff.ctrl     <= hb_host_pkg::CTRL_RST;
      q_ff.period   <= hb_host_pkg::PERIOD_RST;
      q_ff.on_time  <= hb_host_pkg::ON_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;
  assign prdata      = q_ff.rdata;
  // high level is cleared on every stop, so the pin comes straight from a flop
  assign pwm_level   = q_ff.pwm_hi;
  assign pwm_drive_n = !q_ff.pwm_drv;
  assign drv_enable  = q_ff.ctrl[hb_host_pkg::CTRL_DRV_EN_BIT];
  // the line is only ever pulled low, never driven high
  assign fault_out   = 1'b0;
  assign fault_oe_n  = !q_ff.ctrl[hb_host_pkg::CTRL_OWN_FLT_BIT];

  // helper: cycles the current driven level has stood
  logic [7:0] hold_ff;
  logic [1:0] lvl_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff     <= 8'h00;
      lvl_prev_ff <= 2'h0;
    end else begin
      lvl_prev_ff <= {q_ff.pwm_drv, q_ff.pwm_hi};
      if ({q_ff.pwm_drv, q_ff.pwm_hi} != lvl_prev_ff) begin
        hold_ff <= 8'h01;
      end else if (hold_ff != 8'hff) begin
        hold_ff <= hold_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_min_pulse;
    (q_ff.pwm_drv && $past(q_ff.pwm_drv) && $changed(q_ff.pwm_hi))
      |-> ($past(hold_ff) >= 8'(hb_host_pkg::MIN_PULSE_CYC));
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("driven level too short");

  property p_high_after_refresh;
    $rose(q_ff.st == hb_host_pkg::ST_RUN)
      |-> ($past(q_ff.pulses) == LAST_PULSE) && q_ff.pwm_hi && q_ff.pwm_drv;
  endproperty
  a_high_after_refresh: assert property (p_high_after_refresh)
    else $error("run entered without full refresh");

  property p_high_only_in_run;
    pwm_level |-> (q_ff.st == hb_host_pkg::ST_RUN);
  endproperty
  a_high_only_in_run: assert property (p_high_only_in_run)
    else $error("high command outside run");

  property p_refresh_low_len;
    (q_ff.st == hb_host_pkg::ST_REFRESH_MID && $past(q_ff.st) == hb_host_pkg::ST_REFRESH_LOW)
      |-> $past(q_ff.st, 2) == hb_host_pkg::ST_REFRESH_LOW && !$past(pwm_level, 2);
  endproperty
  a_refresh_low_len: assert property (p_refresh_low_len)
    else $error("refresh low phase wrong length");

  property p_fault_stops;
    (fault_low && q_ff.st != hb_host_pkg::ST_IDLE) |=> pwm_drive_n ##1 pwm_drive_n;
  endproperty
  a_fault_stops: assert property (p_fault_stops) else $error("fault did not float command");

  property p_own_fault;
    (wr_en && paddr == hb_host_pkg::CTRL_OFF && pwdata[hb_host_pkg::CTRL_OWN_FLT_BIT])
      |=> !fault_oe_n && !fault_out;
  endproperty
  a_own_fault: assert property (p_own_fault) else $error("own fault not driven low");

  c_reach_run:   cover property ($rose(q_ff.st == hb_host_pkg::ST_RUN));
  c_fault_abort: cover property (q_ff.st == hb_host_pkg::ST_RUN && fault_low);
  c_apb_error:   cover property (pslverr);

endmodule

/* hw/hb_host_pkg.sv */
// package for the half-bridge gate driver controller: register map, states, timing
// assumes a 20 MHz pclk; every figure used by the design files is named here
package hb_host_pkg;

  // clock period and documented times, each in its own unit
  localparam int CLK_PERIOD_NS     = 50;
  localparam int MIN_PULSE_NS      = 20;
  localparam int REFRESH_LOW_NS    = 100;
  localparam int REFRESH_MID_NS    = 100;
  localparam int REFRESH_PULSES    = 32;

  // least times round up to whole cycles, never below one
  localparam int MIN_PULSE_RAW     = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYC     = (MIN_PULSE_RAW < 1) ? 1 : MIN_PULSE_RAW;
  localparam int REFRESH_LOW_RAW   = (REFRESH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_LOW_CYC   = (REFRESH_LOW_RAW < 1) ? 1 : REFRESH_LOW_RAW;
  localparam int REFRESH_MID_RAW   = (REFRESH_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_MID_CYC   = (REFRESH_MID_RAW < 1) ? 1 : REFRESH_MID_RAW;

  localparam int TIMER_W           = 16;
  localparam int PULSE_W           = 6;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h04;
  localparam logic [7:0] ON_OFF     = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;

  // control field positions
  localparam int CTRL_RUN_BIT      = 0;
  localparam int CTRL_OWN_FLT_BIT  = 1;
  localparam int CTRL_DRV_EN_BIT   = 2;
  localparam int CTRL_W            = 3;

  // status field positions
  localparam int STAT_STATE_LSB    = 0;
  localparam int STAT_FLT_LVL_BIT  = 4;
  localparam int STAT_FLT_SEEN_BIT = 5;
  localparam int STAT_PULSE_LSB    = 8;

  // reset values
  localparam logic [CTRL_W-1:0]  CTRL_RST   = 3'h0;
  localparam logic [TIMER_W-1:0] PERIOD_RST = 16'h0014;
  localparam logic [TIMER_W-1:0] ON_RST     = 16'h000a;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REFRESH_LOW,
    ST_REFRESH_MID,
    ST_RUN
  } host_st_t;

endpackage

/* hw/phase_timer.sv */
// down-counting phase timer: load a count, expired once it reaches zero
// assumes the loader asks for load only in cycles where it starts a new phase
module phase_timer #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_t;

  timer_state_t q_ff;
  timer_state_t nxt_q;

  // load wins over counting; the counter parks at zero
  always_comb begin
    nxt_q = q_ff;
    if (load) begin
      nxt_q.cnt = load_val;
    end else if (q_ff.cnt != '0) begin
      nxt_q.cnt = q_ff.cnt - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign expired = (q_ff.cnt == '0);

endmodule
